// [design/adc_clockgen_and_postcorrection.sv]
`timescale 1ns/10ps
module adc_clockgen_and_postcorrection #(
  parameter int CIC_W = 50
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire adc_pkg::power_state_t power_state,
  input  wire logic                 vt_is_temp,
  input  wire logic [1:0]           stream2_bit,
  input  wire logic [1:0]           stream3_bit,
  output logic                      mod_clk,
  output logic                      chop_clk,
  output adc_pkg::chan_flags_t      cur_flags,
  output adc_pkg::chan_flags_t      vt_flags,
  output logic [1:0]                line_enables,
  output logic                      result_valid,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import adc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [9:0]  lp_div_reg;        // lowpower_modulator_divider
  logic [9:0]  fp_div_reg;        // fullpower_modulator_divider
  logic [2:0]  chop_pos_reg;      // chop_clock_position
  logic [1:0]  mod_pos_reg;       // modulator_clock_position
  logic [23:0] off_reg [3];       // Current, voltage, temperature offsets
  logic [23:0] gain_reg [3];      // Same order, temp keeps 16 bits
  logic [2:0]  osr_reg;           // Oversampling select
  logic [1:0]  avg_reg;           // averaging_select
  logic [1:0]  strobe_en_reg;     // Bit0 current, bit1 volt/temp
  logic [1:0]  chop_sel_reg;      // chop_divider_select
  logic        chop_en_reg;       // Chopping on
  logic [5:0]  shift_reg;         // Post shift: cur, volt, temp
  logic [1:0]  line_en_reg;       // interrupt_line_enables
  logic [23:0] res_reg [2];       // Latest corrected results

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite decode; both write channels are taken in one cycle
  logic        wr_rdy_reg;
  logic        rd_rdy_reg;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_take;
  logic        rd_take;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;

  assign wr_idx  = s_axi_awaddr[9:2];
  assign rd_idx  = s_axi_araddr[9:2];
  assign wr_take = wr_rdy_reg & s_axi_awvalid & s_axi_wvalid;
  assign rd_take = rd_rdy_reg & s_axi_arvalid;
  assign wmask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  // Upper address bits must be clear for a hit
  assign wr_hit  = (s_axi_awaddr[11:10] == 2'h0) &&
                   (wr_idx inside {IDX_LP_DIV_LO, IDX_LP_DIV_HI,
                    IDX_FP_DIV_LO, IDX_FP_HI_POS, IDX_CUR_GAIN,
                    IDX_CUR_OFF, IDX_VOLT_GAIN, IDX_VOLT_OFF,
                    IDX_TEMP_GAIN, IDX_TEMP_OFF, IDX_SAMPLING,
                    IDX_RANGE_CHK, IDX_CONV_MODE, IDX_POST_SHIFT,
                    IDX_LINE_EN});
  assign s_axi_awready = wr_rdy_reg;
  assign s_axi_wready  = wr_rdy_reg;
  assign s_axi_arready = rd_rdy_reg;

  // Read selection
  always_comb begin
    rd_hit  = s_axi_araddr[11:10] == 2'h0;
    rd_word = 32'h0;
    // Unused clock config bits read zero
    // zero fill
    unique case (rd_idx)
      IDX_LP_DIV_LO:  rd_word = {24'h0, lp_div_reg[7:0]};
      IDX_LP_DIV_HI:  rd_word = {30'h0, lp_div_reg[9:8]};
      IDX_FP_DIV_LO:  rd_word = {24'h0, fp_div_reg[7:0]};
      IDX_FP_HI_POS:  rd_word = {24'h0, mod_pos_reg, chop_pos_reg,
                                 1'b0, fp_div_reg[9:8]};
      IDX_CUR_GAIN:   rd_word = {8'h0, gain_reg[0]};
      IDX_CUR_OFF:    rd_word = {8'h0, off_reg[0]};
      IDX_VOLT_GAIN:  rd_word = {8'h0, gain_reg[1]};
      IDX_VOLT_OFF:   rd_word = {8'h0, off_reg[1]};
      IDX_TEMP_GAIN:  rd_word = {16'h0, gain_reg[2][15:0]};
      IDX_TEMP_OFF:   rd_word = {16'h0, off_reg[2][15:0]};
      IDX_SAMPLING:   rd_word = {27'h0, avg_reg, osr_reg};
      IDX_RANGE_CHK:  rd_word = {30'h0, strobe_en_reg};
      IDX_CONV_MODE:  rd_word = {29'h0, chop_en_reg, chop_sel_reg};
      IDX_POST_SHIFT: rd_word = {26'h0, shift_reg};
      IDX_LINE_EN:    rd_word = {16'h0, line_en_reg, 14'h0};
      IDX_RES_CUR:    rd_word = {8'h0, res_reg[0]};
      IDX_RES_VT:     rd_word = {8'h0, res_reg[1]};
      default:        rd_hit  = 1'b0;
    endcase
  end

  // Handshake: ready one cycle after valid, answer the cycle after
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_rdy_reg   <= 1'b0;
      rd_rdy_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end else begin
      wr_rdy_reg <= ~wr_rdy_reg & ~s_axi_bvalid &
                    s_axi_awvalid & s_axi_wvalid;
      rd_rdy_reg <= ~rd_rdy_reg & ~s_axi_rvalid & s_axi_arvalid;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata  <= rd_hit ? rd_word : 32'h0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; unstrobed byte lanes write as zero, lane 0 strobe gates all but line enables
  logic [31:0] wd;
  assign wd = s_axi_wdata & wmask;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lp_div_reg    <= {2'h0, RST_LP_DIV_LO};
      fp_div_reg    <= {2'h0, RST_FP_DIV_LO};
      chop_pos_reg  <= RST_CHOP_POS;
      mod_pos_reg   <= RST_MOD_POS;
      off_reg       <= '{3{24'h0}};
      gain_reg      <= '{RST_GAIN24, RST_GAIN24, {8'h0, RST_GAIN16}};
      osr_reg       <= 3'h0;
      avg_reg       <= 2'h0;
      strobe_en_reg <= 2'h0;
      chop_sel_reg  <= 2'h0;
      chop_en_reg   <= 1'b0;
      shift_reg     <= 6'h0;
      line_en_reg   <= 2'h0;
    end else if (wr_take && s_axi_wstrb[0]) begin
      // Lane 0 carries the byte registers, line enables aside; wider ones mask per lane
      unique case (wr_idx)
        IDX_LP_DIV_LO: lp_div_reg[7:0] <= wd[7:0];
        IDX_LP_DIV_HI: lp_div_reg[9:8] <= wd[1:0];
        IDX_FP_DIV_LO: fp_div_reg[7:0] <= wd[7:0];
        IDX_FP_HI_POS: begin
          fp_div_reg[9:8] <= wd[1:0];
          chop_pos_reg <= (wd[5:3] > 3'(CHOP_MAXPOS)) ?
                          3'(CHOP_MAXPOS) : wd[5:3];
          mod_pos_reg  <= wd[7:6];
        end
        IDX_CUR_GAIN:   gain_reg[0] <= wd[23:0];
        IDX_CUR_OFF:    off_reg[0]  <= wd[23:0];
        IDX_VOLT_GAIN:  gain_reg[1] <= wd[23:0];
        IDX_VOLT_OFF:   off_reg[1]  <= wd[23:0];
        IDX_TEMP_GAIN:  gain_reg[2] <= {8'h0, wd[15:0]};
        IDX_TEMP_OFF:   off_reg[2]  <= {8'h0, wd[15:0]};
        IDX_SAMPLING: begin
          osr_reg <= (wd[2:0] > 3'(OSR_MAX)) ? 3'(OSR_MAX) : wd[2:0];
          avg_reg <= wd[4:3];
        end
        IDX_RANGE_CHK:  strobe_en_reg <= wd[1:0];
        IDX_CONV_MODE:  {chop_en_reg, chop_sel_reg} <= wd[2:0];
        IDX_POST_SHIFT: shift_reg <= wd[5:0];
        // line enables ride on lane 1
        IDX_LINE_EN:    if (s_axi_wstrb[1]) line_en_reg <= wd[15:14];
        default: ;
      endcase
    end else if (wr_take && wr_idx == IDX_LINE_EN && s_axi_wstrb[1]) begin
      line_en_reg <= wd[15:14];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base clock: fractional accumulator, exact average rate
  localparam logic [14:0] ACC_MOD  = 15'(CORE_KHZ);
  localparam logic [14:0] ACC_HALF = 15'(CORE_KHZ / 2);
  logic        low_power;
  logic [14:0] acc_reg;
  logic [14:0] acc_sum;
  logic [14:0] acc_next;
  logic        base_reg;
  logic        base_rise;
  logic        base_fall;
  logic [4:0]  tick_dly_reg;

  assign low_power = power_state != FULL_POWER_STATE;
  assign acc_sum   = acc_reg + (low_power ? 15'(LP_KHZ) : 15'(FP_KHZ));
  assign acc_next  = (acc_sum >= ACC_MOD) ? acc_sum - ACC_MOD : acc_sum;
  assign base_rise = (acc_next < ACC_HALF) & ~base_reg;
  assign base_fall = (acc_next >= ACC_HALF) & base_reg;

  // Base level and a short delay line for position shifting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_reg      <= 15'h0;
      base_reg     <= 1'b0;
      tick_dly_reg <= 5'h0;
    end else begin
      acc_reg      <= acc_next;
      base_reg     <= acc_next < ACC_HALF;
      tick_dly_reg <= {tick_dly_reg[3:0], base_rise};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator and chop clock dividers
  logic       mod_tick;
  logic       chop_tick;
  logic [9:0] div_sel;
  logic [9:0] div_eff;
  logic [9:0] mod_cnt_reg;
  logic       mod_toggle;
  logic [2:0] chop_pos_eff;
  logic [3:0] chop_cnt_reg;
  logic       chop_due_reg;
  logic       mod_rise;

  // LP uses falling base edge, no shift
  // modulator base delayed one to four cycles
  assign mod_tick  = low_power ? base_fall : tick_dly_reg[mod_pos_reg];
  assign chop_pos_eff = chop_pos_reg;
  // chop base delayed zero to four cycles
  assign chop_tick = low_power ? base_fall :
                     (chop_pos_eff == 3'h0) ? base_rise :
                     tick_dly_reg[chop_pos_eff - 3'h1];
  assign div_sel   = low_power ? lp_div_reg : fp_div_reg;
  // zero acts as divide by two
  assign div_eff   = (div_sel == 10'h0) ? 10'h1 : div_sel;
  assign mod_toggle = mod_tick && (mod_cnt_reg >= div_eff - 10'h1);
  assign mod_rise  = mod_toggle & ~mod_clk;

  // Half-period counting in base ticks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mod_cnt_reg  <= 10'h0;
      mod_clk      <= 1'b0;
      chop_clk     <= 1'b0;
      chop_cnt_reg <= 4'h0;
      chop_due_reg <= 1'b0;
    end else begin
      if (mod_toggle) begin
        mod_cnt_reg <= 10'h0;
        mod_clk     <= ~mod_clk;
      end else if (mod_tick) begin
        mod_cnt_reg <= mod_cnt_reg + 10'h1;
      end
      // Pending toggle applied on the chop base edge; a new request wins
      if (chop_due_reg && chop_tick) begin
        chop_clk     <= ~chop_clk;
        chop_due_reg <= 1'b0;
      end
      // chop toggles every 2^sel modulator periods
      if (mod_rise) begin
        chop_cnt_reg <= (chop_cnt_reg >= (4'h1 << chop_sel_reg) - 4'h1) ?
                        4'h0 : chop_cnt_reg + 4'h1;
        if (chop_cnt_reg >= (4'h1 << chop_sel_reg) - 4'h1)
          chop_due_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path, one lane per converter channel
  logic [1:0]  avg_eff;
  logic [5:0]  cic_shift;
  logic [10:0] dec_n;             // Up to 2047 at the largest ratio
  logic [10:0] dec_cnt_reg;
  logic        dec_done;
  logic [1:0]  res_ovr;
  logic [1:0]  res_ovf;
  assign avg_eff   = chop_en_reg ? 2'h1 : avg_reg;
  assign dec_n     = 11'((1 << (DEC_BASE_LOG + int'(osr_reg))) - 1);
  assign dec_done  = mod_rise && dec_cnt_reg == dec_n;
  assign cic_shift = 6'(1 + 4 * int'(osr_reg));

  // Shared decimation phase counter
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      dec_cnt_reg <= 11'h0;
    else if (dec_done)
      dec_cnt_reg <= 11'h0;
    else if (mod_rise)
      dec_cnt_reg <= dec_cnt_reg + 11'h1;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_lane
      logic [2:0]             s3_hist_reg;
      logic signed [4:0]      ns_val;
      logic signed [CIC_W-1:0] integ_reg [4];
      logic signed [CIC_W-1:0] comb_dly_reg [4];
      logic signed [CIC_W-1:0] comb [5];
      logic signed [CIC_W-1:0] scaled;
      logic signed [31:0]     x0;
      logic signed [31:0]     x1_reg;
      logic signed [31:0]     x2_reg;
      logic signed [33:0]     avg_val;
      logic signed [23:0]     clamped;
      logic                   over;
      logic signed [24:0]     with_off;
      logic signed [24:0]     gain_u;
      logic signed [49:0]     prod;
      logic signed [33:0]     shifted;
      logic                   ovf;
      logic [1:0]             ps;
      logic signed [23:0]     off_s;

      // MASH-style third-order shaping of third stream
      assign ns_val = (stream2_bit[ch] ? 5'sd1 : -5'sd1)
        + (stream3_bit[ch] ? 5'sd1 : -5'sd1)
        - 5'sd3 * (s3_hist_reg[0] ? 5'sd1 : -5'sd1)
        + 5'sd3 * (s3_hist_reg[1] ? 5'sd1 : -5'sd1)
        - (s3_hist_reg[2] ? 5'sd1 : -5'sd1);

      // Comb cascade over decimated integrator output
      assign comb[0] = integ_reg[3];
      for (genvar k = 0; k < 4; k++) begin : g_comb
        assign comb[k+1] = comb[k] - comb_dly_reg[k];
      end
      assign scaled = comb[4] >>> cic_shift;
      assign x0     = scaled[31:0];

      assign avg_val = (avg_eff == 2'h1) ?
                       (34'(x0) + 34'(x1_reg)) >>> 1 :
                       (avg_eff == 2'h2) ?
                       (34'(x0) + (34'(x1_reg) <<< 1) + 34'(x2_reg)) >>> 2 :
                       34'(x0);

      assign over    = avg_val > 34'(signed'(RANGE_HI)) ||
                       avg_val < 34'(signed'(RANGE_LO));
      assign clamped = (avg_val > 34'(signed'(RANGE_HI))) ? RANGE_HI :
                       (avg_val < 34'(signed'(RANGE_LO))) ? RANGE_LO :
                       avg_val[23:0];

      // Channel 1 corrects as voltage or temperature
      assign off_s = (ch == 0) ? off_reg[0] :
                     vt_is_temp ? {off_reg[2][15:0], 8'h0} : off_reg[1];
      assign gain_u = (ch == 0) ? {1'b0, gain_reg[0]} :
                      vt_is_temp ? {1'b0, gain_reg[2][15:0], 8'h0} :
                      {1'b0, gain_reg[1]};
      assign ps = (ch == 0) ? shift_reg[1:0] :
                  vt_is_temp ? shift_reg[5:4] : shift_reg[3:2];
      assign with_off = 25'(clamped) + 25'(off_s);
      assign prod     = 50'(with_off) * 50'(gain_u);
      // post shift left by 0, 1, 2 or 3 bits
      assign shifted  = 34'(prod >>> FRAC_BITS) <<< ps;
      assign ovf = shifted > 34'(signed'(FRAC_MAX)) ||
                   shifted < 34'(signed'(FRAC_MIN));
      assign res_ovr[ch] = over;
      assign res_ovf[ch] = ovf;

      // Capture, integrate, decimate, average, correct
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          s3_hist_reg  <= 3'h0;
          integ_reg    <= '{4{'0}};
          comb_dly_reg <= '{4{'0}};
          x1_reg       <= 32'sh0;
          x2_reg       <= 32'sh0;
          res_reg[ch]  <= 24'h0;
        end else begin
          if (mod_rise) begin
            s3_hist_reg  <= {s3_hist_reg[1:0], stream3_bit[ch]};
            integ_reg[0] <= integ_reg[0] + CIC_W'(ns_val);
            integ_reg[1] <= integ_reg[1] + integ_reg[0];
            integ_reg[2] <= integ_reg[2] + integ_reg[1];
            integ_reg[3] <= integ_reg[3] + integ_reg[2];
          end
          if (dec_done) begin
            comb_dly_reg <= comb[0:3];
            x1_reg       <= x0;
            x2_reg       <= x1_reg;
            res_reg[ch]  <= !ovf ? shifted[23:0] :
                            shifted[33] ? FRAC_MIN : FRAC_MAX;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Strobes toward the interrupt controller
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur_flags    <= '0;
      vt_flags     <= '0;
      result_valid <= 1'b0;
      line_enables <= 2'h0;
    end else begin
      cur_flags.overrange <= dec_done & res_ovr[0] & strobe_en_reg[0];
      vt_flags.overrange  <= dec_done & res_ovr[1] & strobe_en_reg[1];
      cur_flags.overflow  <= dec_done & res_ovf[0] & strobe_en_reg[0];
      vt_flags.overflow   <= dec_done & res_ovf[1] & strobe_en_reg[1];
      result_valid        <= dec_done;
      line_enables        <= line_en_reg;
    end
  end
endmodule

// [design/adc_pkg.sv]
package adc_pkg;
  // Register indices; byte address is index * 4
  localparam logic [7:0] IDX_LP_DIV_LO  = 8'hb0;
  localparam logic [7:0] IDX_LP_DIV_HI  = 8'hb1;
  localparam logic [7:0] IDX_FP_DIV_LO  = 8'hb2;
  localparam logic [7:0] IDX_FP_HI_POS  = 8'hb3;
  localparam logic [7:0] IDX_CUR_GAIN   = 8'h30;
  localparam logic [7:0] IDX_CUR_OFF    = 8'h33;
  localparam logic [7:0] IDX_VOLT_GAIN  = 8'h36;
  localparam logic [7:0] IDX_VOLT_OFF   = 8'h39;
  localparam logic [7:0] IDX_TEMP_GAIN  = 8'h3c;
  localparam logic [7:0] IDX_TEMP_OFF   = 8'h3e;
  localparam logic [7:0] IDX_SAMPLING   = 8'hc0;
  localparam logic [7:0] IDX_RANGE_CHK  = 8'hc1;
  localparam logic [7:0] IDX_CONV_MODE  = 8'hc2;
  localparam logic [7:0] IDX_POST_SHIFT = 8'hc3;
  localparam logic [7:0] IDX_LINE_EN    = 8'hc4;
  localparam logic [7:0] IDX_RES_CUR    = 8'hc5;
  localparam logic [7:0] IDX_RES_VT     = 8'hc6;
  // Reset values
  localparam logic [7:0]  RST_LP_DIV_LO = 8'h18;
  localparam logic [7:0]  RST_FP_DIV_LO = 8'h08;
  localparam logic [2:0]  RST_CHOP_POS  = 3'h2;
  localparam logic [1:0]  RST_MOD_POS   = 2'h2;
  localparam logic [23:0] RST_GAIN24    = 24'h800000;
  localparam logic [15:0] RST_GAIN16    = 16'h8000;
  // Field positions in the clock-position byte and the line-enable register
  localparam int POS_CHOP_LSB = 3;
  localparam int POS_MOD_LSB  = 6;
  localparam int POS_LINE_LSB = 14;
  // Clock rates in kHz
  localparam int CORE_KHZ = 25000;
  localparam int FP_KHZ   = 4000;
  localparam int LP_KHZ   = 125;
  // Fraction limits, Q1.23
  localparam logic [23:0] RANGE_HI = 24'h5fffff;
  localparam logic [23:0] RANGE_LO = 24'ha00000;
  localparam logic [23:0] FRAC_MAX = 24'h7fffff;
  localparam logic [23:0] FRAC_MIN = 24'h800000;
  localparam int FRAC_BITS  = 23;
  localparam int CHOP_MAXPOS = 4;
  localparam int OSR_MAX    = 5;
  localparam int DEC_BASE_LOG = 6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FULL_POWER_STATE,
    LOW_POWER_STATE,
    ULTRA_LOW_POWER_STATE
  } power_state_t;

  // Per-channel strobes toward the interrupt controller
  typedef struct packed {
    logic overrange;
    logic overflow;
  } chan_flags_t;
endpackage

// [bench/modulator_model.sv]
`timescale 1ns/10ps
// Far-side modulators: two bit streams per channel
module modulator_model (
  input  wire logic       core_clk,
  input  wire logic       mod_clk,
  input  wire logic [1:0] level,
  output logic [1:0]      s2_bit,
  output logic [1:0]      s3_bit
);
  logic mod_q; // Last seen modulator clock
  initial begin
    s2_bit = 2'h0;
    s3_bit = 2'h0;
    mod_q = 1'b0;
  end
  // Same level on both streams keeps the shaped sum at DC
  always @(posedge core_clk) begin
    mod_q <= mod_clk;
    if (mod_clk && !mod_q) begin
      s2_bit <= level;
      s3_bit <= level;
    end
  end
endmodule

// [bench/adc_clockgen_and_postcorrection_properties.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module cpc_checker (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 mod_clk,
  input wire logic                 chop_clk,
  input wire adc_pkg::chan_flags_t cur_flags,
  input wire adc_pkg::chan_flags_t vt_flags,
  input wire logic [1:0]           line_enables,
  input wire logic                 result_valid,
  input wire logic                 s_axi_bvalid
);
  import adc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Phase moves may trim a half period by a few cycles only
  AST_MOD_HI: assert property ($rose(mod_clk) |-> mod_clk[*4])
    else $error("modulator high phase too short");
  AST_MOD_LO: assert property ($fell(mod_clk) |-> !mod_clk[*4])
    else $error("modulator low phase too short");
  AST_CHOP_HI: assert property ($rose(chop_clk) |-> chop_clk[*4])
    else $error("chop high phase too short");
  AST_CHOP_LO: assert property ($fell(chop_clk) |-> !chop_clk[*4])
    else $error("chop low phase too short");
  AST_CUR_FLAG: assert property (cur_flags != 2'h0 |=> cur_flags == 2'h0)
    else $error("current strobe longer than one cycle");
  AST_VT_FLAG: assert property (vt_flags != 2'h0 |=> vt_flags == 2'h0)
    else $error("volt/temp strobe longer than one cycle");
  AST_RESULT: assert property (result_valid |=> !result_valid[*8])
    else $error("results closer than one decimation");
  AST_LINE_EN: assert property ($changed(line_enables)
    |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("line enables moved without a write");
endmodule
////////////////////////////////////////////////////////////////////////
bind adc_clockgen_and_postcorrection cpc_checker chk_u (.core_clk,
  .sys_rst, .mod_clk, .chop_clk, .cur_flags, .vt_flags, .line_enables,
  .result_valid, .s_axi_bvalid);

// [bench/adc_clockgen_and_postcorrection_tb_top.sv]
`timescale 1ns/10ps
module adc_clockgen_and_postcorrection_tb_top;
  import adc_pkg::*;
  logic         core_clk = 1'b0;
  logic         sys_rst = 1'b1;
  power_state_t pst = FULL_POWER_STATE;
  logic [1:0]   lvl = 2'h0;
  logic         vtt = 1'b0, seen_vt = 1'b0;
  logic [11:0]  s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_rready = 1'b0, seen_or = 1'b0, seen_of = 1'b0;
  logic [1:0]   s2, s3, line_enables, s_axi_bresp, s_axi_rresp;
  logic         mod_clk, chop_clk, result_valid, s_axi_awready;
  logic         s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  chan_flags_t  cur_flags, vt_flags;
  int           err_count = 0, check_count = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////
  adc_clockgen_and_postcorrection dut_u (.core_clk, .sys_rst,
    .power_state(pst), .vt_is_temp(vtt), .stream2_bit(s2),
    .stream3_bit(s3), .mod_clk, .chop_clk, .cur_flags, .vt_flags,
    .line_enables, .result_valid, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  modulator_model mdl_u (.core_clk, .mod_clk, .level(lvl), .s2_bit(s2),
    .s3_bit(s3));
  always #20 core_clk = ~core_clk;
  // Sticky strobe capture and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cur_flags.overrange) seen_or <= 1'b1;
    if (cur_flags.overflow) seen_of <= 1'b1;
    if (vt_flags.overrange) seen_vt <= 1'b1;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(logic [7:0] i, logic [31:0] d, logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(logic [7:0] i, logic [31:0] e, logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask
  // Period in core cycles over n periods, one cycle of jitter allowed
  task automatic per(logic c, int n, int e);
    realtime t0;
    int k;
    repeat (2) @(posedge (c ? chop_clk : mod_clk));
    t0 = $realtime;
    repeat (n) @(posedge (c ? chop_clk : mod_clk));
    k = int'(($realtime - t0) / 40.0);
    if (k - e <= 1 && e - k <= 1) k = e;
    chk("period", e, k);
  endtask
  task automatic wres(int n);
    repeat (n) @(posedge result_valid);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(IDX_LP_DIV_LO, RST_LP_DIV_LO, RESP_OKAY);
    rd(IDX_FP_DIV_LO, RST_FP_DIV_LO, RESP_OKAY);
    rd(IDX_FP_HI_POS, {RST_MOD_POS, RST_CHOP_POS, 3'h0}, RESP_OKAY);
    wr(IDX_LP_DIV_HI, 32'h3, RESP_OKAY);
    rd(IDX_LP_DIV_HI, 32'h3, RESP_OKAY);
    wr(IDX_FP_HI_POS, 32'h38, RESP_OKAY);
    rd(IDX_FP_HI_POS, 32'h20, RESP_OKAY);
    wr(8'hff, 32'h0, RESP_SLVERR);
    rd(8'hff, 32'h0, RESP_SLVERR);
    wr(IDX_RES_CUR, 32'h1, RESP_SLVERR);
    wr(IDX_LP_DIV_HI, 32'h0, RESP_OKAY);
    $display("t_regs done");
  endtask
  task automatic t_clk();
    pst <= LOW_POWER_STATE;
    wr(IDX_LP_DIV_LO, 32'h3, RESP_OKAY);
    per(1'b0, 1, 6 * CORE_KHZ / LP_KHZ);
    wr(IDX_LP_DIV_LO, 32'h0, RESP_OKAY);
    wr(IDX_CONV_MODE, 32'h4, RESP_OKAY);
    per(1'b0, 1, 2 * CORE_KHZ / LP_KHZ);
    per(1'b1, 1, 4 * CORE_KHZ / LP_KHZ);
    pst <= ULTRA_LOW_POWER_STATE;
    per(1'b0, 1, 2 * CORE_KHZ / LP_KHZ);
    pst <= FULL_POWER_STATE;
    wr(IDX_FP_DIV_LO, 32'h0, RESP_OKAY);
    per(1'b0, 8, 8 * 2 * CORE_KHZ / FP_KHZ);
    wr(IDX_FP_DIV_LO, 32'h2, RESP_OKAY);
    wr(IDX_CONV_MODE, 32'h7, RESP_OKAY);
    per(1'b0, 4, 4 * 4 * CORE_KHZ / FP_KHZ);
    per(1'b1, 1, 16 * 4 * CORE_KHZ / FP_KHZ);
    wr(IDX_FP_DIV_LO, 32'h0, RESP_OKAY);
    wr(IDX_CONV_MODE, 32'h0, RESP_OKAY);
    $display("t_clk done");
  endtask
  task automatic t_data();
    wr(IDX_RANGE_CHK, 32'h3, RESP_OKAY);
    lvl <= 2'h3;
    wres(6);
    rd(IDX_RES_CUR, {8'h0, RANGE_HI}, RESP_OKAY);
    chk("overrange", 1'b1, seen_or);
    wr(IDX_RANGE_CHK, 32'h0, RESP_OKAY);
    wres(2);
    seen_or <= 1'b0;
    wres(3);
    chk("gated", 1'b0, seen_or);
    wr(IDX_CUR_OFF, 32'h1, RESP_OKAY);
    wr(IDX_CUR_GAIN, 32'h400000, RESP_OKAY);
    wres(3);
    rd(IDX_RES_CUR, 32'h300000, RESP_OKAY);
    wr(IDX_CUR_OFF, 32'h0, RESP_OKAY);
    wr(IDX_CUR_GAIN, {8'h0, RST_GAIN24}, RESP_OKAY);
    wr(IDX_POST_SHIFT, 32'h1, RESP_OKAY);
    wr(IDX_RANGE_CHK, 32'h3, RESP_OKAY);
    wres(3);
    rd(IDX_RES_CUR, {8'h0, FRAC_MAX}, RESP_OKAY);
    chk("overflow", 1'b1, seen_of);
    wr(IDX_POST_SHIFT, 32'h0, RESP_OKAY);
    lvl <= 2'h0;
    wres(6);
    rd(IDX_RES_VT, {8'h0, RANGE_LO}, RESP_OKAY);
    chk("vt_overrange", 1'b1, seen_vt);
    vtt <= 1'b1;
    wr(IDX_TEMP_GAIN, 32'h4000, RESP_OKAY);
    wres(2);
    rd(IDX_RES_VT, 32'hd00000, RESP_OKAY);
    wr(IDX_LINE_EN, 32'hc000, RESP_OKAY);
    @(posedge core_clk);
    chk("line_enables", 2'h3, line_enables);
    $display("t_data done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_clk();
    t_data();
    end_sim();
  end
endmodule
